// [rtl/tpm_defines.svh]
`ifndef TPM_DEFINES_SVH
`define TPM_DEFINES_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define TPM_NCH 8
`define TPM_CW 16
`define TPM_SYN_W 10
`define TPM_SYN_EXT 8
`define TPM_SYN_FIX 9

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TPM_OFF_SC 8'h00
`define TPM_OFF_CNT 8'h04
`define TPM_OFF_MOD 8'h08
`define TPM_OFF_CH0 8'h10
`define TPM_CH_STRIDE 8'h08
`define TPM_CH_VAL 8'h04

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TPM_SC_OVF 7
`define TPM_SC_IE 6
`define TPM_SC_CAS 5
`define TPM_SC_CLK_LSB 3
`define TPM_SC_PS_LSB 0
`define TPM_CH_FLAG 7
`define TPM_CH_IE 6
`define TPM_CH_MS_LSB 4
`define TPM_CH_ELS_LSB 2

// ----------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------
`define TPM_CLK_NONE 2'h0
`define TPM_CLK_BUS 2'h1
`define TPM_CLK_FIX 2'h2
`define TPM_CLK_EXT 2'h3
`define TPM_MS_CAPTURE 2'h0
`define TPM_MS_COMPARE 2'h1
`define TPM_ELS_OFF 2'h0
`define TPM_ELS_A 2'h1
`define TPM_ELS_B 2'h2
`define TPM_ELS_AB 2'h3

// ----------------------------------------------------------------
// Reset and count values
// ----------------------------------------------------------------
`define TPM_CNT_ZERO 16'h0000
`define TPM_CNT_ONE 16'h0001
`define TPM_MOD_ALL1 16'hffff
`define TPM_RST_CNT 16'h0000
`define TPM_RST_MOD 16'h0000
`define TPM_RST_CLKS 2'h0
`define TPM_RST_PS 3'h0

`endif

// [rtl/tpm_pkg.sv]
`include "tpm_defines.svh"

package tpm_pkg;

	typedef struct packed {
		logic [`TPM_SYN_W-1:0] stage1;
		logic [`TPM_SYN_W-1:0] stage2;
	} tpm_sync_t;

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [`TPM_SYN_W-1:0] syn_prev;
		logic [`TPM_CW-1:0] timer_counter;
		logic dir_down;
		logic [6:0] presc;
		logic [`TPM_CW-1:0] modulo_value;
		logic overflow_flag;
		logic ovf_arm;
		logic ovf_ie;
		logic center_align_select;
		logic [1:0] clock_source_select;
		logic [2:0] prescale_sel;
		logic [`TPM_NCH-1:0][`TPM_CW-1:0] channel_value;
		logic [`TPM_NCH-1:0] ch_flag;
		logic [`TPM_NCH-1:0] ch_arm;
		logic [`TPM_NCH-1:0] ch_ie;
		logic [`TPM_NCH-1:0][1:0] mode_select;
		logic [`TPM_NCH-1:0][1:0] edge_level_select;
		logic [`TPM_NCH-1:0] ch_pin;
	} tpm_state_t;

endpackage

// [rtl/tpm_sync.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tpm_defines.svh"

module tpm_sync (
	input wire logic clk, // Bus clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic [`TPM_SYN_W-1:0] async_in, // Raw pin levels
	output logic [`TPM_SYN_W-1:0] sync_out // Levels on the bus clock
);

	tpm_pkg::tpm_sync_t s, next_s;

	always_comb begin
		next_s = s;
		next_s.stage1 = async_in;
		next_s.stage2 = s.stage1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign sync_out = s.stage2;

endmodule
`default_nettype wire

// [rtl/tpm_core.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tpm_defines.svh"

module tpm_core (
	input wire logic clk, // Bus clock, 100 MHz
	input wire logic rst, // Synchronous reset, active high
	input wire logic [7:0] avs_address, // Byte address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [31:0] avs_writedata, // Write data
	input wire logic [3:0] avs_byteenable, // Byte lanes
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Stall
	input wire logic background_debug_mode, // Debug active
	input wire logic fixed_clock_in, // Fixed system clock
	input wire logic ext_timer_clock_pin, // External clock pin
	input wire logic [`TPM_NCH-1:0] channel_pin_in, // Pin levels
	output logic [`TPM_NCH-1:0] channel_pin_out, // Pin drive value
	output logic [`TPM_NCH-1:0] channel_pin_oe, // Timer owns pin
	output logic irq_overflow, // Overflow interrupt
	output logic [`TPM_NCH-1:0] irq_channel // Channel interrupts
);

	tpm_pkg::tpm_state_t s, next_s;

	logic [`TPM_SYN_W-1:0] syn;
	logic req, rd_acc, wr_acc;
	logic [7:0] adr;
	logic sel_sc, sel_cnt, sel_mod, cnt_wr, sc_wr;
	logic fix_rise, ext_rise, src_tick, cnt_tick;
	logic [6:0] presc_mask;
	logic [`TPM_CW-1:0] top, cnt_adv, cnt_up, cnt_dn;
	logic at_top, at_zero, dir_adv, ovf_evt, period_start;
	logic [`TPM_NCH-1:0] ch_sel_ctl, ch_sel_val, ch_match, cap_evt;
	logic [`TPM_NCH-1:0] ch_evt, pin_rise, pin_fall;

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronizers
	// ----------------------------------------------------------------
	// two-flop sync of clocks
	tpm_sync u_sync (
		.clk(clk),
		.rst(rst),
		.async_in({fixed_clock_in, ext_timer_clock_pin, channel_pin_in}),
		.sync_out(syn)
	);

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	// One wait state: read data is sampled in the first cycle
	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & ~s.ack;
	assign rd_acc = avs_read & s.ack;
	assign wr_acc = avs_write & s.ack;
	assign avs_readdata = s.rdata;
	assign adr = {avs_address[7:2], 2'b00};
	assign sel_sc = (adr == `TPM_OFF_SC);
	assign sel_cnt = (adr == `TPM_OFF_CNT);
	assign sel_mod = (adr == `TPM_OFF_MOD);
	assign sc_wr = wr_acc & sel_sc & avs_byteenable[0];
	assign cnt_wr = wr_acc & sel_cnt & (|avs_byteenable[1:0]);

	// ----------------------------------------------------------------
	// Clock source and prescaler
	// ----------------------------------------------------------------
	// edges need four bus cycles per period
	assign fix_rise = syn[`TPM_SYN_FIX] & ~s.syn_prev[`TPM_SYN_FIX];
	assign ext_rise = syn[`TPM_SYN_EXT] & ~s.syn_prev[`TPM_SYN_EXT];
	assign src_tick =
		(s.clock_source_select == `TPM_CLK_BUS) |
		((s.clock_source_select == `TPM_CLK_FIX) & fix_rise) |
		((s.clock_source_select == `TPM_CLK_EXT) & ext_rise);
	assign presc_mask = 7'((8'h01 << s.prescale_sel) - 8'h01);
	assign cnt_tick = src_tick & ~background_debug_mode &
		((s.presc & presc_mask) == presc_mask);

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	// zero or all-ones runs free
	assign top = ((s.modulo_value == `TPM_CNT_ZERO) ||
		(s.modulo_value == `TPM_MOD_ALL1)) ? `TPM_MOD_ALL1 :
		s.modulo_value;
	assign at_top = (s.timer_counter == top);
	assign at_zero = (s.timer_counter == `TPM_CNT_ZERO);
	assign cnt_up = s.timer_counter + `TPM_CNT_ONE;
	assign cnt_dn = s.timer_counter - `TPM_CNT_ONE;
	// up to modulo, down to zero
	assign dir_adv = s.center_align_select &
		(s.dir_down ? ~at_zero : at_top);
	// wrap after modulo, period modulo plus one
	assign cnt_adv = ~s.center_align_select ?
		(at_top ? `TPM_CNT_ZERO : cnt_up) : (dir_adv ? cnt_dn : cnt_up);
	assign ovf_evt = cnt_tick & at_top &
		~(s.center_align_select & s.dir_down);
	// one period start shared by all channels
	assign period_start = cnt_tick & ~s.center_align_select &
		(cnt_adv == `TPM_CNT_ZERO);

	// ----------------------------------------------------------------
	// Per-channel decode
	// ----------------------------------------------------------------
	// one slice per channel
	for (genvar i = 0; i < `TPM_NCH; i++) begin : g_ch
		assign ch_sel_ctl[i] =
			(adr == 8'(`TPM_OFF_CH0 + i * `TPM_CH_STRIDE));
		assign ch_sel_val[i] =
			(adr == 8'(`TPM_OFF_CH0 + i * `TPM_CH_STRIDE + `TPM_CH_VAL));
		assign ch_match[i] = cnt_tick & (cnt_adv == s.channel_value[i]);
		assign pin_rise[i] = syn[i] & ~s.syn_prev[i];
		assign pin_fall[i] = ~syn[i] & s.syn_prev[i];
		assign cap_evt[i] = ~s.center_align_select &
			(s.mode_select[i] == `TPM_MS_CAPTURE) &
			(s.clock_source_select != `TPM_CLK_NONE) & (
			((s.edge_level_select[i] == `TPM_ELS_A) & pin_rise[i]) |
			((s.edge_level_select[i] == `TPM_ELS_B) & pin_fall[i]) |
			((s.edge_level_select[i] == `TPM_ELS_AB) &
			(pin_rise[i] | pin_fall[i])));
		// compare still flags with pin off
		assign ch_evt[i] = cap_evt[i] | (ch_match[i] &
			(s.center_align_select |
			(s.mode_select[i] != `TPM_MS_CAPTURE)));
		// pin released unless compare or PWM output is on
		assign channel_pin_oe[i] =
			(s.clock_source_select != `TPM_CLK_NONE) &
			(s.edge_level_select[i] != `TPM_ELS_OFF) &
			(s.center_align_select |
			(s.mode_select[i] != `TPM_MS_CAPTURE));
		assign irq_channel[i] = s.ch_flag[i] & s.ch_ie[i];
	end

	assign channel_pin_out = s.ch_pin;
	assign irq_overflow = s.overflow_flag & s.ovf_ie;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.ack = req & ~s.ack;
		next_s.syn_prev = syn;
		if (req & ~s.ack) begin
			next_s.rdata = 32'h0000_0000;
			if (sel_sc) begin
				next_s.rdata[`TPM_SC_OVF] = s.overflow_flag;
				next_s.rdata[`TPM_SC_IE] = s.ovf_ie;
				next_s.rdata[`TPM_SC_CAS] = s.center_align_select;
				next_s.rdata[`TPM_SC_CLK_LSB +: 2] = s.clock_source_select;
				next_s.rdata[`TPM_SC_PS_LSB +: 3] = s.prescale_sel;
			end
			// counter read has no side effect
			if (sel_cnt) next_s.rdata[15:0] = s.timer_counter;
			if (sel_mod) next_s.rdata[15:0] = s.modulo_value;
			for (int i = 0; i < `TPM_NCH; i++) begin
				if (ch_sel_ctl[i]) begin
					next_s.rdata[`TPM_CH_FLAG] = s.ch_flag[i];
					next_s.rdata[`TPM_CH_IE] = s.ch_ie[i];
					next_s.rdata[`TPM_CH_MS_LSB +: 2] = s.mode_select[i];
					next_s.rdata[`TPM_CH_ELS_LSB +: 2] = s.edge_level_select[i];
				end
				if (ch_sel_val[i]) next_s.rdata[15:0] = s.channel_value[i];
			end
		end
		// wait mode needs nothing, stop just loses clk
		if (src_tick & ~background_debug_mode)
			next_s.presc = s.presc + 7'h01;
		if (cnt_tick) begin
			next_s.timer_counter = cnt_adv;
			next_s.dir_down = dir_adv;
		end
		if (cnt_wr) begin
			next_s.timer_counter = `TPM_RST_CNT;
			next_s.dir_down = 1'b0;
			next_s.presc = 7'h00;
		end
		// one select bit for center mode
		if (sc_wr) begin
			next_s.ovf_ie = avs_writedata[`TPM_SC_IE];
			next_s.center_align_select = avs_writedata[`TPM_SC_CAS];
			next_s.clock_source_select =
				avs_writedata[`TPM_SC_CLK_LSB +: 2];
			next_s.prescale_sel = avs_writedata[`TPM_SC_PS_LSB +: 3];
		end
		if (wr_acc & sel_mod) next_s.modulo_value =
			merge16(s.modulo_value, avs_writedata, avs_byteenable);
		// Arm on the value software actually saw, not the live flag
		// read-then-write-zero clear, set wins
		if (rd_acc & sel_sc & s.rdata[`TPM_SC_OVF]) next_s.ovf_arm = 1'b1;
		if (sc_wr & ~avs_writedata[`TPM_SC_OVF] & s.ovf_arm) begin
			next_s.overflow_flag = 1'b0;
			next_s.ovf_arm = 1'b0;
		end
		if (ovf_evt) begin
			next_s.overflow_flag = 1'b1;
			next_s.ovf_arm = 1'b0;
		end
		for (int i = 0; i < `TPM_NCH; i++) begin
			if (wr_acc & ch_sel_ctl[i] & avs_byteenable[0]) begin
				next_s.ch_ie[i] = avs_writedata[`TPM_CH_IE];
				next_s.mode_select[i] = avs_writedata[`TPM_CH_MS_LSB +: 2];
				next_s.edge_level_select[i] =
					avs_writedata[`TPM_CH_ELS_LSB +: 2];
			end
			if (wr_acc & ch_sel_val[i]) next_s.channel_value[i] =
				merge16(s.channel_value[i], avs_writedata, avs_byteenable);
			if (cap_evt[i]) next_s.channel_value[i] = s.timer_counter;
			if (s.edge_level_select[i] != `TPM_ELS_OFF) begin
				if (s.center_align_select) begin
					// with TPM_ELS_B set on down match, clear on up match; A and AB invert
					if (ch_match[i]) next_s.ch_pin[i] =
						dir_adv ^ s.edge_level_select[i][0];
				end else if (s.mode_select[i][1]) begin
					// with TPM_ELS_B high at period start, low on match; A and AB invert
					if (period_start)
						next_s.ch_pin[i] = ~s.edge_level_select[i][0];
					if (ch_match[i])
						next_s.ch_pin[i] = s.edge_level_select[i][0];
				end else if (s.mode_select[i] == `TPM_MS_COMPARE) begin
					// toggle, clear or set on match
					if (ch_match[i]) begin
						unique case (s.edge_level_select[i])
							`TPM_ELS_A: next_s.ch_pin[i] = ~s.ch_pin[i];
							`TPM_ELS_B: next_s.ch_pin[i] = 1'b0;
							default: next_s.ch_pin[i] = 1'b1;
						endcase
					end
				end
			end
			// flag at duty transition, set wins over clear
			if (rd_acc & ch_sel_ctl[i] & s.rdata[`TPM_CH_FLAG])
				next_s.ch_arm[i] = 1'b1;
			if (wr_acc & ch_sel_ctl[i] & avs_byteenable[0] &
				~avs_writedata[`TPM_CH_FLAG] & s.ch_arm[i]) begin
				next_s.ch_flag[i] = 1'b0;
				next_s.ch_arm[i] = 1'b0;
			end
			if (ch_evt[i]) begin
				next_s.ch_flag[i] = 1'b1;
				next_s.ch_arm[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
			s.timer_counter <= `TPM_RST_CNT;
			s.modulo_value <= `TPM_RST_MOD;
			s.clock_source_select <= `TPM_RST_CLKS;
			s.prescale_sel <= `TPM_RST_PS;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_cnt_reset;
		cnt_wr |=> s.timer_counter == `TPM_RST_CNT;
	endproperty
	a_cnt_reset: assert property (p_cnt_reset)
		else $error("counter write did not reset counter");
	property p_ovf_flag;
		ovf_evt |=> s.overflow_flag && irq_overflow == s.ovf_ie;
	endproperty
	a_ovf_flag: assert property (p_ovf_flag)
		else $error("overflow did not set flag");
	property p_free_wrap;
		cnt_tick && !s.center_align_select && !cnt_wr &&
		s.modulo_value == `TPM_RST_MOD &&
		s.timer_counter == `TPM_MOD_ALL1 |=>
		s.timer_counter == `TPM_CNT_ZERO && s.overflow_flag;
	endproperty
	a_free_wrap: assert property (p_free_wrap)
		else $error("free-running counter did not wrap");
	property p_bdm_hold;
		background_debug_mode && !cnt_wr |=> $stable(s.timer_counter);
	endproperty
	a_bdm_hold: assert property (p_bdm_hold)
		else $error("counter moved in debug mode");
	property p_off_idle;
		s.clock_source_select == `TPM_CLK_NONE |->
		channel_pin_oe == '0 && !cnt_tick && !(|cap_evt);
	endproperty
	a_off_idle: assert property (p_off_idle)
		else $error("timer active with clock off");
	property p_capture;
		cap_evt[0] |=> s.channel_value[0] == $past(s.timer_counter) &&
		s.ch_flag[0];
	endproperty
	a_capture: assert property (p_capture)
		else $error("capture did not store counter");
	property p_presc_gap;
		cnt_tick && s.prescale_sel == 3'h1 && !sc_wr |=> !cnt_tick;
	endproperty
	a_presc_gap: assert property (p_presc_gap)
		else $error("divide-by-2 ticked twice in a row");
	// Channel 2 is one of the channels that software drives as a PWM output
	property p_edge_aligned_pwm_start;
		period_start && s.mode_select[2][1] && !ch_match[2] &&
		s.edge_level_select[2] == `TPM_ELS_B |=> s.ch_pin[2];
	endproperty
	a_edge_aligned_pwm_start: assert property (p_edge_aligned_pwm_start)
		else $error("edge PWM not high at period start");
	property p_center_aligned_pwm_down;
		s.center_align_select && ch_match[2] && dir_adv &&
		s.edge_level_select[2] == `TPM_ELS_B |=> s.ch_pin[2];
	endproperty
	a_center_aligned_pwm_down: assert property (p_center_aligned_pwm_down)
		else $error("center PWM not set on down match");
	// A modulo of one turns back at once, so only the first step is checked
	property p_center_aligned_pwm_turn;
		cnt_tick && s.center_align_select && !s.dir_down && at_top &&
		!cnt_wr |=> s.dir_down && s.timer_counter == $past(cnt_dn);
	endproperty
	a_center_aligned_pwm_turn: assert property (p_center_aligned_pwm_turn)
		else $error("center counter did not turn at modulo");
	property p_irq;
		ch_evt[0] && s.ch_ie[0] && !(wr_acc && ch_sel_ctl[0]) |=>
		irq_channel[0];
	endproperty
	a_irq: assert property (p_irq)
		else $error("channel event gave no interrupt");

	c_ovf: cover property (ovf_evt);
	c_capture: cover property (cap_evt[0]);
	c_center_aligned_pwm_turn: cover property (s.center_align_select && $rose(s.dir_down));
	c_read: cover property (rd_acc && sel_cnt);

endmodule
`default_nettype wire

// [testbench/tpm_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Far side: channel pins and clock sources
// ----------------------------------------
module tpm_pin_model (
	input wire logic clk, // Bus clock
	input wire logic [7:0] pin_out, // Timer drive value
	input wire logic [7:0] pin_oe, // Timer owns pin
	input wire logic [7:0] pin_drv, // Level from outside
	input wire logic ext_run, // External source enabled
	output logic [7:0] pin_lvl, // Resolved pin levels
	output logic fix_clk, // Free-running system clock
	output logic ext_clk // External clock, still when idle
);
	logic [2:0] div;
	initial div = 3'h0;
	always @(posedge clk) begin
		div <= div + 3'h1;
	end
	assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & pin_drv);
	assign fix_clk = div[2];
	assign ext_clk = ext_run & div[1];
endmodule
`default_nettype wire

// [testbench/timer_capture_compare_pwm_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tpm_defines.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
$display("BAD %0t got %h want %h", $time, a, b); end end
module timer_capture_compare_pwm_tb;
	logic clk, rst, rd_en, wr_en, dbg, ext_run, wait_req, irq_ovf;
	logic fix_clk, ext_clk;
	logic [3:0] be;
	logic [7:0] addr, pin_out, pin_oe, pin_drv, pin_lvl, irq_ch;
	logic [31:0] wdata, rdata, q;
	logic [15:0] c1, c2;
	int fails, tests_run, cyc, n, r;
	int e1[4] = '{0, 1, 0, 1};
	int e2[4] = '{0, 1, 0, 0};
	int els[4] = '{0, 3, 2, 1};
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	tpm_core DUT (.clk(clk), .rst(rst), .avs_address(addr),
		.avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdata),
		.avs_byteenable(be), .avs_readdata(rdata),
		.avs_waitrequest(wait_req), .background_debug_mode(dbg),
		.fixed_clock_in(fix_clk), .ext_timer_clock_pin(ext_clk),
		.channel_pin_in(pin_lvl), .channel_pin_out(pin_out),
		.channel_pin_oe(pin_oe), .irq_overflow(irq_ovf),
		.irq_channel(irq_ch));
	tpm_pin_model pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_drv(pin_drv), .ext_run(ext_run), .pin_lvl(pin_lvl),
		.fix_clk(fix_clk), .ext_clk(ext_clk));
	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// A hung handshake ends here instead of spinning forever
	always @(posedge clk) begin
		cyc++;
		if (cyc > 30000) begin
			fails++;
			stop_test();
		end
	end
	// ----------------------------------------
	// Avalon master: hold until waitrequest low
	// ----------------------------------------
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [15:0] d);
		@(posedge clk);
		rd_en <= !w;
		wr_en <= w;
		addr <= a;
		wdata <= {16'h0000, d};
		do @(posedge clk); while (wait_req !== 1'b0);
		q = rdata;
		rd_en <= 1'b0;
		wr_en <= 1'b0;
	endtask
	// Two counter reads whose requests start k+3 cycles apart
	task automatic meas(input logic [7:0] sc, input int k,
		input int frz);
		bus(1, `TPM_OFF_SC, {8'h00, sc});
		bus(0, `TPM_OFF_CNT, 16'h0000);
		c1 = q[15:0];
		repeat (k - frz) @(posedge clk);
		dbg <= frz > 0;
		repeat (frz) @(posedge clk);
		dbg <= 1'b0;
		bus(0, `TPM_OFF_CNT, 16'h0000);
		c2 = q[15:0];
	endtask
	// High cycles of one pin, and rises of it without a rise of ch 2
	task automatic hits(input int ch, input int len);
		logic [7:0] prv;
		n = 0;
		r = 0;
		prv = pin_out;
		repeat (len) begin
			@(posedge clk);
			if (pin_out[ch] === 1'b1) n++;
			if (pin_out[ch] && !prv[ch] && !(pin_out[2] && !prv[2])) r++;
			prv = pin_out;
		end
	endtask
	function automatic logic [7:0] ca(input int ch, input int v);
		return `TPM_OFF_CH0 + 8'(ch) * `TPM_CH_STRIDE + 8'(v);
	endfunction
	initial begin
		rst = 1'b1;
		rd_en = 1'b0;
		wr_en = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		be = 4'hf;
		dbg = 1'b0;
		ext_run = 1'b0;
		pin_drv = 8'h00;
		fails = 0;
		tests_run = 0;
		cyc = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		// ----------------------------------------
		// Reset state and unmapped place
		// ----------------------------------------
		@(posedge clk);
		`CHK(pin_oe, 8'h00)
		`CHK({irq_ovf, irq_ch}, 9'h000)
		foreach (els[i]) begin
			bus(0, 8'h04 * 8'(i), 16'h0000);
			`CHK(q, 32'h0)
		end
		bus(1, 8'h0c, 16'h5a5a);
		bus(0, 8'h0c, 16'h0000);
		`CHK(q, 32'h0)
		$display("reset test done");
		// ----------------------------------------
		// Clock sources, prescaler, debug freeze
		// ----------------------------------------
		for (int p = 0; p < 8; p++) begin
			meas(8'h08 | 8'(p), 253, 0);
			`CHK(16'(c2 - c1), 16'(256 >> p))
		end
		meas(8'h00, 253, 0);
		`CHK(16'(c2 - c1), 16'h0000)
		meas(8'h10, 253, 0);
		`CHK(16'(c2 - c1), 16'h0020)
		ext_run <= 1'b1;
		meas(8'h18, 253, 0);
		`CHK(16'(c2 - c1), 16'h0040)
		ext_run <= 1'b0;
		meas(8'h08, 253, 100);
		`CHK(16'(c2 - c1), 16'h009c)
		be <= 4'h2;
		bus(1, `TPM_OFF_CNT, 16'hffff);
		be <= 4'hf;
		bus(0, `TPM_OFF_CNT, 16'h0000);
		`CHK(q[15:0] < 16'h0004, 1'b1)
		bus(1, `TPM_OFF_MOD, 16'h0009);
		meas(8'h08, 4, 0);
		`CHK(c1 < 16'h000a, 1'b1)
		`CHK(c2, 16'((c1 + 7) % 10))
		$display("counter test done");
		// ----------------------------------------
		// Overflow flag and its two-step clear
		// ----------------------------------------
		bus(1, `TPM_OFF_MOD, 16'h00ff);
		bus(1, `TPM_OFF_SC, 16'h0048);
		repeat (300) @(posedge clk);
		bus(1, `TPM_OFF_CNT, 16'h0000);
		bus(0, `TPM_OFF_SC, 16'h0000);
		`CHK(q[7], 1'b1)
		`CHK(irq_ovf, 1'b1)
		bus(1, `TPM_OFF_SC, 16'h0048);
		bus(0, `TPM_OFF_SC, 16'h0000);
		`CHK({q[7], irq_ovf}, 2'b00)
		repeat (300) @(posedge clk);
		bus(1, `TPM_OFF_SC, 16'h0048);
		bus(0, `TPM_OFF_SC, 16'h0000);
		`CHK(q[7], 1'b1)
		$display("overflow test done");
		// ----------------------------------------
		// Capture on ch 0 for every edge choice
		// ----------------------------------------
		bus(1, `TPM_OFF_MOD, 16'h0000);
		bus(1, `TPM_OFF_SC, 16'h000f);
		for (int s = 0; s < 4; s++) begin
			bus(1, ca(0, 0), 16'(8'h40 | 8'(s << 2)));
			for (int e = 0; e < 2; e++) begin
				pin_drv[0] <= (e == 0);
				repeat (8) @(posedge clk);
				bus(0, `TPM_OFF_CNT, 16'h0000);
				c1 = q[15:0];
				`CHK(irq_ch[0], 1'(s >> e))
				bus(0, ca(0, 0), 16'h0000);
				`CHK(q[7], 1'(s >> e))
				`CHK(pin_oe[0], 1'b0)
				bus(1, ca(0, 0), 16'(8'h40 | 8'(s << 2)));
				bus(0, ca(0, 4), 16'h0000);
				if (s == 1 && e == 0) begin
					`CHK(q[15:0] == c1 || q[15:0] == c1 - 1, 1'b1)
				end
			end
		end
		$display("capture test done");
		// ----------------------------------------
		// Compare on ch 1: none, set, clear, toggle
		// ----------------------------------------
		bus(1, `TPM_OFF_MOD, 16'h00ff);
		bus(1, `TPM_OFF_SC, 16'h0008);
		bus(1, ca(1, 4), 16'h0080);
		foreach (els[i]) begin
			bus(1, `TPM_OFF_CNT, 16'h0000);
			bus(1, ca(1, 0), 16'(8'h10 | 8'(els[i] << 2)));
			repeat (256) @(posedge clk);
			`CHK(pin_oe[1], 1'(els[i] != 0))
			if (i > 0) `CHK(pin_out[1], 1'(e1[i]))
			repeat (256) @(posedge clk);
			if (i > 0) `CHK(pin_out[1], 1'(e2[i]))
			bus(0, ca(1, 0), 16'h0000);
			`CHK(q[7], 1'b1)
			bus(1, ca(1, 0), 16'h0000);
		end
		$display("compare test done");
		// ----------------------------------------
		// Edge PWM on ch 2 and 3, then center PWM
		// ----------------------------------------
		bus(1, `TPM_OFF_MOD, 16'h0009);
		// Count is above the new modulo; restart it or it runs to 0xffff
		bus(1, `TPM_OFF_CNT, 16'h0000);
		bus(1, ca(2, 4), 16'h0003);
		bus(1, ca(3, 4), 16'h0005);
		bus(1, ca(2, 0), 16'h0028);
		bus(1, ca(3, 0), 16'h0028);
		repeat (30) @(posedge clk);
		hits(2, 20);
		`CHK(n, 6)
		hits(3, 20);
		`CHK(n, 10)
		`CHK(r, 0)
		bus(0, ca(2, 0), 16'h0000);
		`CHK(q[7], 1'b1)
		bus(1, ca(2, 0), 16'h0024);
		repeat (30) @(posedge clk);
		hits(2, 20);
		`CHK(n, 14)
		bus(1, ca(2, 0), 16'h0028);
		bus(1, `TPM_OFF_SC, 16'h0028);
		repeat (40) @(posedge clk);
		hits(2, 36);
		`CHK(n, 12)
		`CHK(pin_oe[0], 1'b1)
		$display("pwm test done");
		stop_test();
	end
endmodule
`default_nettype wire
